// ---- rtl/dafc_pkg.sv ----
package dafc_pkg;

    // ----------------------------------------------------------------
    // Register window and offsets
    // ----------------------------------------------------------------
    // Width of the compared window base, address lines 15 down to 4.
    localparam int unsigned BASE_W        = 12;
    // Lowest base the window may take, in units of 16 bytes.
    localparam logic [11:0] BASE_MIN      = 12'h010;
    // Command register: channel, scan, gain, enables, line select, timer run.
    localparam logic [3:0]  OFS_COMMAND   = 4'h0;
    // Status register: flags, pending sources, current channel.
    localparam logic [3:0]  OFS_STATUS    = 4'h4;
    // Conversion data register, reading pops the oldest result.
    localparam logic [3:0]  OFS_FIFO_DATA = 4'h8;
    // Sample-interval count register.
    localparam logic [3:0]  OFS_INTERVAL  = 4'hc;

    // ----------------------------------------------------------------
    // Command register fields
    // ----------------------------------------------------------------
    localparam int unsigned CMD_CHAN_LSB    = 0;
    localparam int unsigned CMD_SCAN_BIT    = 4;
    localparam int unsigned CMD_GAIN_LSB    = 5;
    localparam int unsigned CMD_EXTIE_BIT   = 7;
    localparam int unsigned CMD_FIFOIE_BIT  = 8;
    localparam int unsigned CMD_CTR2IE_BIT  = 9;
    localparam int unsigned CMD_IRQSEL_LSB  = 10;
    localparam int unsigned CMD_TIMER_BIT   = 13;
    localparam int unsigned CMD_W           = 14;
    localparam logic [13:0] CMD_RESET       = 14'h0000;

    // ----------------------------------------------------------------
    // Status register fields
    // ----------------------------------------------------------------
    localparam int unsigned STS_NEMPTY_BIT  = 0;
    localparam int unsigned STS_OVFL_BIT    = 1;
    localparam int unsigned STS_FIFOP_BIT   = 2;
    localparam int unsigned STS_EXTP_BIT    = 3;
    localparam int unsigned STS_CTR2P_BIT   = 4;
    localparam int unsigned STS_CHAN_LSB    = 5;

    // ----------------------------------------------------------------
    // Interrupt lines, converter and timing
    // ----------------------------------------------------------------
    // Six request lines in order 3, 4, 5, 6, 7 and 9.
    localparam int unsigned IRQ_LINES       = 6;
    localparam int unsigned ADC_W           = 12;
    localparam int unsigned WORD_W          = 16;
    localparam int unsigned FIFO_DEPTH      = 256;
    localparam logic [15:0] INTERVAL_RESET  = 16'hffff;
    // Clock period and timebase period in nanoseconds.
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned TICK_PERIOD_NS  = 1000;
    localparam int unsigned TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [6:0]  TICK_LAST       = 7'(TICK_CYCLES - 1);

endpackage : dafc_pkg

// ---- rtl/dafc_top.sv ----
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module dafc_top #(
    parameter int unsigned DEPTH = dafc_pkg::FIFO_DEPTH
) (
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    input  wire logic                          clk_en,
    input  wire logic [dafc_pkg::BASE_W-1:0]   assigned_base,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [31:0]                   paddr,
    input  wire logic [31:0]                   pwdata,
    output logic [31:0]                        prdata,
    output logic                               pready,
    output logic                               pslverr,
    output logic [dafc_pkg::IRQ_LINES-1:0]     irq_lines,
    input  wire logic                          external_interrupt_request_n,
    input  wire logic                          external_convert_trigger_n,
    input  wire logic                          general_counter_two_output,
    output logic                               sample_timer_output,
    output logic                               adc_convert_start,
    input  wire logic                          adc_done,
    input  wire logic [dafc_pkg::ADC_W-1:0]    adc_result,
    output logic [3:0]                         mux_channel,
    output logic [1:0]                         gain_select
);
    import dafc_pkg::*;

    localparam int unsigned PW = $clog2(DEPTH);

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // Widens a converter result by copying its sign bit upward.
    function automatic logic [WORD_W-1:0] sign_extend(input logic [ADC_W-1:0] v);
        sign_extend = {{(WORD_W - ADC_W){v[ADC_W-1]}}, v};
    endfunction : sign_extend

    // Two-stage synchronisers for outside pins.
    logic [3+ADC_W:0] sync1_r;           // First stage, read only by second.
    logic [3+ADC_W:0] sync2_r;           // Second stage, safe to use.
    logic [1:0]       edge_r;            // Previous trigger and counter-two.
    logic             done_d_r;          // Previous converter done level.

    logic [CMD_W-1:0]  cmd_r;            // Command register.
    logic [15:0]       interval_r;       // Programmed sample-interval count.
    logic [15:0]       count_r;          // Running sample-interval count.
    logic [6:0]        tick_cnt_r;       // Divider to the 1 MHz timebase.
    logic              timer_out_r;      // Sample timer output level.
    logic              timer_d_r;        // Previous timer output level.
    logic              convert_r;        // Convert start pulse register.
    logic [3:0]        chan_r;           // Channel the multiplexer sees.
    logic              overflow_r;       // Sticky overflow flag.
    logic              ctr2_pend_r;      // Sticky counter-two rise flag.
    logic [WORD_W-1:0] mem_r [DEPTH];    // FIFO storage.
    logic [PW:0]       wr_ptr_r;         // FIFO write pointer.
    logic [PW:0]       rd_ptr_r;         // FIFO read pointer.
    logic [31:0]       rdata_r;          // Read data register.

    // Synchronised pin views.
    logic             ext_int_n_s;
    logic             trig_n_s;
    logic             ctr2_s;
    logic             done_s;
    logic [ADC_W-1:0] result_s;

    assign ext_int_n_s = sync2_r[0];
    assign trig_n_s    = sync2_r[1];
    assign ctr2_s      = sync2_r[2];
    assign done_s      = sync2_r[3];
    assign result_s    = sync2_r[3+ADC_W:4];

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic board_sel;                     // Window matched.
    logic setup_ph;                      // Setup cycle of a transfer.
    logic access_ph;                     // Access cycle of a transfer.
    logic wr_cmd;                        // Write pulse, command register.
    logic wr_sts;                        // Write pulse, status register.
    logic wr_int;                        // Write pulse, interval register.
    logic rd_fifo;                       // Read pulse, data register.
    logic fifo_empty;
    logic fifo_full;
    logic fifo_push;
    logic fifo_pop;
    logic done_rise;
    logic [31:0] status_word;

    // The window sits at or above 0x100 and is 16-byte aligned by construction.
    assign board_sel = (paddr[31:16] == 16'h0000)
                     && (paddr[15:4] == assigned_base)
                     && (assigned_base >= BASE_MIN);
    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable && clk_en;
    assign wr_cmd  = access_ph && board_sel && pwrite && paddr[3:0] == OFS_COMMAND;
    assign wr_sts  = access_ph && board_sel && pwrite && paddr[3:0] == OFS_STATUS;
    assign wr_int  = access_ph && board_sel && pwrite && paddr[3:0] == OFS_INTERVAL;
    assign rd_fifo = access_ph && board_sel && !pwrite
                   && paddr[3:0] == OFS_FIFO_DATA;
    // The slave answers in the first access cycle; misses are errors.
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !board_sel;
    assign prdata  = rdata_r;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Converter, trigger, counter-two and interrupt pins pass two flip-flops before use.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            // Active-low pins reset to idle high, so no false edge follows.
            sync1_r <= 16'h0003;
            sync2_r <= 16'h0003;
        end
        else if (clk_en)
        begin
            sync1_r <= {adc_result, adc_done, general_counter_two_output,
                        external_convert_trigger_n, external_interrupt_request_n};
            sync2_r <= sync1_r;
        end
    end

    // Edge history for the trigger, counter-two and converter done.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            edge_r   <= 2'b11;
            done_d_r <= 1'b0;
        end
        else if (clk_en)
        begin
            edge_r   <= {ctr2_s, trig_n_s};
            done_d_r <= done_s;
        end
    end

    assign done_rise = done_s && !done_d_r;

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    // Command register steers channel, gain, enables and line select.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cmd_r <= CMD_RESET;
        end
        else if (wr_cmd)
        begin
            cmd_r <= pwdata[CMD_W-1:0];
        end
    end

    // Interval register; the host stops sampling by clearing run.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            interval_r <= INTERVAL_RESET;
        end
        else if (wr_int)
        begin
            interval_r <= pwdata[15:0];
        end
    end

    // ----------------------------------------------------------------
    // Sample-interval timer
    // ----------------------------------------------------------------
    // Divides the clock down to the 1 MHz timebase.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            tick_cnt_r <= '0;
        end
        else if (clk_en)
        begin
            tick_cnt_r <= (tick_cnt_r == TICK_LAST) ? 7'h00 : tick_cnt_r + 7'h01;
        end
    end

    // Down-counts on each tick; at a count of one it pulses low and reloads.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            count_r     <= INTERVAL_RESET;
            timer_out_r <= 1'b1;
        end
        else if (clk_en)
        begin
            if (wr_int || !cmd_r[CMD_TIMER_BIT])
            begin
                // Reprogramming or stopping restarts the count.
                count_r     <= wr_int ? pwdata[15:0] : interval_r;
                timer_out_r <= 1'b1;
            end
            else if (tick_cnt_r == TICK_LAST)
            begin
                if (count_r <= 16'h0001)
                begin
                    count_r     <= interval_r;
                    timer_out_r <= 1'b0;
                end
                else
                begin
                    count_r     <= count_r - 16'h0001;
                    timer_out_r <= 1'b1;
                end
            end
        end
    end

    assign sample_timer_output = timer_out_r;

    // Conversion start from timer fall or trigger rise.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            timer_d_r <= 1'b1;
            convert_r <= 1'b0;
        end
        else if (clk_en)
        begin
            timer_d_r <= timer_out_r;
            convert_r <= (timer_d_r && !timer_out_r)
                       || (trig_n_s && !edge_r[0]);
        end
    end

    assign adc_convert_start = convert_r;

    // ----------------------------------------------------------------
    // Channel and gain
    // ----------------------------------------------------------------
    // Single mode holds the commanded channel; scan steps down and reloads it after channel 0.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            chan_r <= 4'h0;
        end
        else if (wr_cmd)
        begin
            chan_r <= pwdata[CMD_CHAN_LSB+:4];
        end
        else if (clk_en && done_rise && cmd_r[CMD_SCAN_BIT])
        begin
            // Scanning moves to the next lower channel.
            chan_r <= (chan_r == 4'h0) ? cmd_r[CMD_CHAN_LSB+:4]
                                       : chan_r - 4'h1;
        end
    end

    assign mux_channel = chan_r;
    assign gain_select = cmd_r[CMD_GAIN_LSB+:2];

    // ----------------------------------------------------------------
    // Conversion FIFO
    // ----------------------------------------------------------------
    assign fifo_empty = (wr_ptr_r == rd_ptr_r);
    assign fifo_full  = (wr_ptr_r[PW] != rd_ptr_r[PW])
                     && (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]);
    assign fifo_push  = clk_en && done_rise && !fifo_full;
    assign fifo_pop   = rd_fifo && !fifo_empty;

    // Stores each completed result that arrives while not full as a signed 16-bit word.
    always_ff @(posedge ref_clk)
    begin
        if (fifo_push)
        begin
            mem_r[wr_ptr_r[PW-1:0]] <= sign_extend(result_s);
        end
    end

    // Pointer update; a full FIFO drops the arriving result.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end
        else
        begin
            if (fifo_push)
            begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (fifo_pop)
            begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

    // Overflow sets when a result arrives while full; write 1 clears.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            overflow_r <= 1'b0;
        end
        else if (clk_en && done_rise && fifo_full)
        begin
            overflow_r <= 1'b1;
        end
        else if (wr_sts && pwdata[STS_OVFL_BIT])
        begin
            overflow_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt sources and routing
    // ----------------------------------------------------------------
    // Counter-two rise is sticky until written off; a set wins a clear.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ctr2_pend_r <= 1'b0;
        end
        else if (clk_en && ctr2_s && !edge_r[1])
        begin
            ctr2_pend_r <= 1'b1;
        end
        else if (wr_sts && pwdata[STS_CTR2P_BIT])
        begin
            ctr2_pend_r <= 1'b0;
        end
    end

    logic [2:0] pend;                    // Data, external, counter-two.
    logic [2:0] enab;                    // Matching enables.
    logic       irq_any;

    // Data clears by draining the FIFO, external by releasing the pin.
    assign pend    = {ctr2_pend_r, !ext_int_n_s, !fifo_empty};
    assign enab    = {cmd_r[CMD_CTR2IE_BIT], cmd_r[CMD_EXTIE_BIT], cmd_r[CMD_FIFOIE_BIT]};
    assign irq_any = |(pend & enab);

    // Route to the one selected line; codes above five drive none.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            irq_lines <= '0;
        end
        else if (clk_en)
        begin
            irq_lines <= '0;
            if (cmd_r[CMD_IRQSEL_LSB+:3] < 3'(IRQ_LINES))
            begin
                irq_lines[cmd_r[CMD_IRQSEL_LSB+:3]] <= irq_any;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    assign status_word = {23'h000000, chan_r, pend, overflow_r, !fifo_empty};

    // Read data loads in the setup cycle, selected reads only.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_r <= '0;
        end
        else if (clk_en && setup_ph)
        begin
            rdata_r <= '0;
            if (board_sel && !pwrite)
            begin
                unique case (paddr[3:0])
                    OFS_COMMAND:   rdata_r <= {18'h00000, cmd_r};
                    OFS_STATUS:    rdata_r <= status_word;
                    OFS_FIFO_DATA: rdata_r <= fifo_empty ? 32'h00000000
                                        : {16'h0000, mem_r[rd_ptr_r[PW-1:0]]};
                    OFS_INTERVAL:  rdata_r <= {16'h0000, interval_r};
                    default:       rdata_r <= '0;
                endcase
            end
        end
    end

endmodule : dafc_top
`default_nettype wire

// ---- testbench/dafc_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Port properties of the acquisition block
// ------------------------------------------------------------
module dafc_properties
    import dafc_pkg::*;
(
    input wire logic                ref_clk,
    input wire logic                rst,
    input wire logic [BASE_W-1:0]   assigned_base,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [31:0]         paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pslverr,
    input wire logic [5:0]          irq_lines,
    input wire logic                external_convert_trigger_n,
    input wire logic                sample_timer_output,
    input wire logic                adc_convert_start,
    input wire logic [3:0]          mux_channel,
    input wire logic [1:0]          gain_select
);
    // Cycles the sample output has been low.
    logic [7:0] low_cnt_r;
    // Address falls in the board's window.
    logic       in_win;

    assign in_win = paddr[31:4] == {16'h0000, assigned_base};

    // Low-phase length of the sample output.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst) low_cnt_r <= 8'h00;
        else if (sample_timer_output) low_cnt_r <= 8'h00;
        else low_cnt_r <= low_cnt_r + 8'h01;
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // Access phase of a write to the command register.
    sequence cmd_write;
        psel && penable && pwrite && in_win && paddr[3:0] == OFS_COMMAND;
    endsequence
    // Access phase of any read.
    sequence read_acc;
        psel && penable && !pwrite;
    endsequence

    a_window_err: assert property (psel && penable |-> pslverr == !in_win)
        else $error("wrong window error");
    a_one_line: assert property ($onehot0(irq_lines))
        else $error("more than one request line high");
    a_read_width: assert property (read_acc |-> prdata[31:16] == 16'h0000)
        else $error("read upper half set");
    a_chan_load: assert property (cmd_write |=> mux_channel == $past(pwdata[3:0]))
        else $error("channel not loaded from command");
    a_gain_load: assert property (cmd_write |=> gain_select == $past(pwdata[6:5]))
        else $error("gain not loaded from command");
    a_conv_pulse: assert property (adc_convert_start |=> !adc_convert_start)
        else $error("convert pulse too long");
    a_timer_conv: assert property ($fell(sample_timer_output) |-> ##[1:4] adc_convert_start)
        else $error("no convert after timer fall");
    a_trig_conv: assert property ($rose(external_convert_trigger_n) |-> ##[1:6] adc_convert_start)
        else $error("no convert after trigger rise");
    a_tick_width: assert property ($rose(sample_timer_output) |-> low_cnt_r == 8'(TICK_CYCLES))
        else $error("sample pulse width wrong");
endmodule : dafc_properties

bind dafc_top dafc_properties u_props (
    .ref_clk(ref_clk), .rst(rst), .assigned_base(assigned_base), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pslverr(pslverr), .irq_lines(irq_lines), .external_convert_trigger_n(external_convert_trigger_n),
    .sample_timer_output(sample_timer_output), .adc_convert_start(adc_convert_start),
    .mux_channel(mux_channel), .gain_select(gain_select)
);
`default_nettype wire

// ---- testbench/dafc_conv_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Converter model: numbered result per start
// ------------------------------------------------------------
module dafc_conv_model (
    input wire logic         ref_clk,
    input wire logic         rst,
    input wire logic         adc_convert_start,
    output logic             adc_done,
    output logic [11:0]      adc_result
);
    logic [3:0]  step_r = 4'h0;     // Conversion step.
    logic        done_r = 1'b0;     // Result-ready level.
    logic [11:0] res_r  = 12'h000;  // Result lines.
    int          num_r  = 0;        // Conversion number.

    assign adc_done   = done_r;
    assign adc_result = res_r;

    // Done rises three cycles after a start; the result then flips.
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            step_r <= 4'h0;
            done_r <= 1'b0;
            num_r  <= 0;
        end
        else if (adc_convert_start === 1'b1) step_r <= 4'h1;
        else if (step_r != 4'h0)
        begin
            step_r <= step_r + 4'h1;
            if (step_r == 4'h3)
            begin
                done_r <= 1'b1;
                res_r  <= 12'(num_r * 'h137 + 'h7f0);
            end
            if (step_r == 4'h7)
            begin
                done_r <= 1'b0;
                res_r  <= ~res_r;
                num_r  <= num_r + 1;
                step_r <= 4'h0;
            end
        end
    end
endmodule : dafc_conv_model
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dafc_pkg::*;
    localparam logic [31:0] BASE = 32'h00000300;
    logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
    logic pready, pslverr, conv, done, sto;
    logic external_interrupt_request_n = 1'b1, external_convert_trigger_n = 1'b1;
    logic general_counter_two_output = 1'b0;
    logic [5:0] irq_lines;
    logic [11:0] res;
    logic [3:0] mux;
    logic [1:0] gain;
    logic [31:0] q;
    logic e;
    int failures = 0, comparisons = 0, rd_idx = 0, t;

    dafc_top uut (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1), .assigned_base(12'h030),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_lines(irq_lines),
        .external_interrupt_request_n(external_interrupt_request_n),
        .external_convert_trigger_n(external_convert_trigger_n),
        .general_counter_two_output(general_counter_two_output), .sample_timer_output(sto),
        .adc_convert_start(conv), .adc_done(done), .adc_result(res), .mux_channel(mux),
        .gain_select(gain));
    dafc_conv_model u_conv (.ref_clk(ref_clk), .rst(rst), .adc_convert_start(conv),
        .adc_done(done), .adc_result(res));

    always #5 ref_clk = ~ref_clk;

    // Expected FIFO word of conversion k.
    function automatic logic [31:0] exp_word(input int k);
        logic [11:0] v;
        v = 12'(k * 'h137 + 'h7f0);
        return {16'h0000, {4{v[11]}}, v};
    endfunction : exp_word

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        comparisons++;
        if (got !== ex)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    // One transfer, held until pready is high.
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        t = 0;
        do
        begin
            @(posedge ref_clk);
            t++;
        end
        while (pready !== 1'b1 && t < 50);
        if (t >= 50) failures++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [3:0] ofs, input logic [31:0] d);
        apb(1'b1, BASE + 32'(ofs), d);
    endtask : wr

    task automatic rd(input string nm, input logic [3:0] ofs, input logic [31:0] ex);
        apb(1'b0, BASE + 32'(ofs), 32'h0);
        chk(nm, ex, q);
    endtask : rd

    task automatic pop();
        rd("fifo data", OFS_FIFO_DATA, exp_word(rd_idx));
        rd_idx++;
    endtask : pop

    // Pulse the convert input and let the result land.
    task automatic trig();
        @(posedge ref_clk) external_convert_trigger_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        external_convert_trigger_n <= 1'b1;
        repeat (25) @(posedge ref_clk);
    endtask : trig

    task automatic give_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict

    initial
    begin
        repeat (100000) @(posedge ref_clk);
        failures++;
        give_verdict();
    end

    initial
    begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        rd("command reset", OFS_COMMAND, 32'h0);
        rd("interval reset", OFS_INTERVAL, 32'h0000ffff);
        rd("status reset", OFS_STATUS, 32'h0);
        apb(1'b0, 32'h00000400, 32'h0);
        chk("outside window", 32'h1, 32'(e));
        trig();
        rd("status data", OFS_STATUS, 32'h5);
        chk("irq masked", 32'h0, 32'(irq_lines));
        wr(OFS_COMMAND, 32'h0900);
        repeat (4) @(posedge ref_clk);
        chk("irq data", 32'h4, 32'(irq_lines));
        pop();
        repeat (4) @(posedge ref_clk);
        chk("irq drained", 32'h0, 32'(irq_lines));
        rd("status empty", OFS_STATUS, 32'h0);
        external_interrupt_request_n <= 1'b0;
        for (int s = 0; s < 6; s++)
        begin
            wr(OFS_COMMAND, 32'h80 | (s << 10));
            repeat (4) @(posedge ref_clk);
            chk("irq line", 32'h1 << s, 32'(irq_lines));
        end
        rd("status ext", OFS_STATUS, 32'h8);
        wr(OFS_COMMAND, 32'h1400);
        repeat (4) @(posedge ref_clk);
        chk("irq ext off", 32'h0, 32'(irq_lines));
        external_interrupt_request_n <= 1'b1;
        wr(OFS_COMMAND, 32'h0200);
        general_counter_two_output <= 1'b1;
        repeat (6) @(posedge ref_clk);
        general_counter_two_output <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk("irq counter", 32'h1, 32'(irq_lines));
        wr(OFS_STATUS, 32'h10);
        repeat (4) @(posedge ref_clk);
        chk("irq counter clr", 32'h0, 32'(irq_lines));
        wr(OFS_COMMAND, 32'h0053);
        repeat (2) @(posedge ref_clk);
        chk("gain", 32'h2, 32'(gain));
        for (int i = 0; i < 4; i++)
        begin
            trig();
            chk("scan channel", (i < 3) ? 32'(2 - i) : 32'h3, 32'(mux));
        end
        repeat (4) pop();
        wr(OFS_COMMAND, 32'h0005);
        trig();
        trig();
        chk("single channel", 32'h5, 32'(mux));
        repeat (2) pop();
        wr(OFS_INTERVAL, 32'h0014);
        wr(OFS_COMMAND, 32'h2000);
        for (t = 0; t < 5000 && sto !== 1'b0; t++) @(posedge ref_clk);
        for (t = 0; t < 5000 && sto !== 1'b1; t++) @(posedge ref_clk);
        for (int k = t; k < 5000 && sto !== 1'b0; k++, t++) @(posedge ref_clk);
        chk("timer period", 32'd2000, 32'(t));
        wait (sto === 1'b1);
        wr(OFS_COMMAND, 32'h0);
        repeat (2) pop();
        rd("timer stopped", OFS_STATUS, 32'h0);
        repeat (257) trig();
        rd("status overflow", OFS_STATUS, 32'h7);
        repeat (256) pop();
        rd_idx++;
        rd("empty data", OFS_FIFO_DATA, 32'h0);
        wr(OFS_STATUS, 32'h2);
        rd("overflow clear", OFS_STATUS, 32'h0);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
